// [src/swq_axil_slave.sv]
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: register file answers rdData/rdErr combinationally from rdAddr
// Notes: write fires in the first cycle that both address and data are held
`timescale 1ns/1ns
`default_nettype none
`include "swq_regs.svh"
module swq_axil_slave
  import swq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`SWQ_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`SWQ_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic wrEn,
  output logic [`SWQ_ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  output logic [`SWQ_ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);
  typedef struct packed {
    logic awHeld;
    logic [`SWQ_ADDR_W-1:0] addr;
    logic wHeld;
    logic [31:0] data;
    logic [3:0] strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } swq_axs_t;
  swq_axs_t st_ff;
  swq_axs_t nxt_st;
  assign awready = clkEn & ~st_ff.awHeld & ~st_ff.bvalid;
  assign wready = clkEn & ~st_ff.wHeld & ~st_ff.bvalid;
  assign arready = clkEn & ~st_ff.rvalid;
  assign wrEn = clkEn & st_ff.awHeld & st_ff.wHeld & ~st_ff.bvalid;
  assign wrAddr = st_ff.addr;
  assign wrData = st_ff.data;
  assign wrStrb = st_ff.strb;
  assign rdAddr = araddr;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign rvalid = st_ff.rvalid;
  assign rdata = st_ff.rdata;
  assign rresp = st_ff.rresp;
  always_comb begin
    nxt_st = st_ff;
    if (awvalid && awready) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.addr = awaddr;
    end
    if (wvalid && wready) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.data = wdata;
      nxt_st.strb = wstrb;
    end
    if (wrEn) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wrErr ? `SWQ_RESP_SLVERR : `SWQ_RESP_OKAY;
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rdErr ? 32'h00000000 : rdData;
      nxt_st.rresp = rdErr ? `SWQ_RESP_SLVERR : `SWQ_RESP_OKAY;
    end
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// [src/swq_edge_det.sv]
// Purpose: rising and falling edge detect on a vector of event levels
// Assumes: inputs synchronous to sys_clk
// Notes: history resets low, so a level high at release reads as a rise
`timescale 1ns/1ns
`default_nettype none
module swq_edge_det
  import swq_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [W-1:0] sig,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] prev;
  } swq_edge_t;
  swq_edge_t st_ff;
  swq_edge_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = sig;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end
  assign rise = clkEn ? (sig & ~st_ff.prev) : '0;
  assign fall = clkEn ? (~sig & st_ff.prev) : '0;
endmodule
`default_nettype wire

// [src/swq_pkg.sv]
// Purpose: shared types of the wake qualifier
// Assumes: constants live in swq_regs.svh
// Notes: sleep state is reported by the sequencer outside this block
package swq_pkg;
  typedef enum logic [1:0] {
    SWQ_S0 = 2'b00,
    SWQ_SX = 2'b01,
    SWQ_DEEP = 2'b10,
    SWQ_SX_AFTER_DEEP = 2'b11
  } swq_pstate_t;
endpackage

// [src/swq_regs.svh]
// Purpose: register map, field positions and fixed codes of the wake qualifier
// Assumes: included by bare name from the design files
// Notes: permission masks are {reset type, after power loss, deep sleep, ordinary sleep}
`ifndef SWQ_REGS_SVH
`define SWQ_REGS_SVH
`define SWQ_ADDR_W 8
`define SWQ_OFS_CTRL 8'h00
`define SWQ_OFS_STAT 8'h04
`define SWQ_OFS_USBEN 8'h08
`define SWQ_OFS_GPEN0 8'h0C
`define SWQ_OFS_GPST0 8'h18
`define SWQ_WORD_STEP 8'h04
`define SWQ_C_RTC 0
`define SWQ_C_AUDIO 1
`define SWQ_C_B0 2
`define SWQ_C_SEC 3
`define SWQ_C_PCIEDIS 4
`define SWQ_C_HNWK 5
`define SWQ_C_LANOVR 6
`define SWQ_C_ACWK 7
`define SWQ_C_USBDEEP 8
`define SWQ_C_USBMODE 9
`define SWQ_C_ALERTNAT 10
`define SWQ_C_LANGPIO 11
`define SWQ_C_TIER2 12
`define SWQ_CTRL_W 13
`define SWQ_CTRL_RST 13'h0000
`define SWQ_S_WAKE 0
`define SWQ_S_B0 1
`define SWQ_S_SMBWK 2
`define SWQ_S_TIER2 3
`define SWQ_S_RTC 4
`define SWQ_S_PWRBTN 5
`define SWQ_S_LAN 6
`define SWQ_S_PCIE 7
`define SWQ_S_AC 8
`define SWQ_S_USB 9
`define SWQ_S_SEC 10
`define SWQ_S_ME 11
`define SWQ_S_ALERT 12
`define SWQ_S_SLV 13
`define SWQ_STAT_W 14
`define SWQ_STAT_RST 14'h0000
`define SWQ_CTX_SX 4'h1
`define SWQ_CTX_DEEP 4'h2
`define SWQ_CTX_LOSS 4'h4
`define SWQ_CTX_RESET 4'h8
`define SWQ_CTX_NONE 4'h0
`define SWQ_PERM_RTC 4'h7
`define SWQ_PERM_PWRBTN 4'hF
`define SWQ_PERM_GPIO 4'h1
`define SWQ_PERM_LAN 4'hF
`define SWQ_PERM_AUDIO 4'h1
`define SWQ_PERM_PRI 4'h5
`define SWQ_PERM_SEC 4'h5
`define SWQ_PERM_PCIE 4'h7
`define SWQ_PERM_ALERT 4'hD
`define SWQ_PERM_SLV 4'hD
`define SWQ_PERM_HN 4'hD
`define SWQ_PERM_ME 4'hD
`define SWQ_SLV_WAKE_CMD 8'h01
`define SWQ_RST_TYPES 7
`define SWQ_RESP_OKAY 2'h0
`define SWQ_RESP_SLVERR 2'h2
`endif

// [src/swq_wake_qualifier.sv]
// Purpose: qualify wake sources against enables and present sleep context
// Assumes: sleep state, power loss and reset cause come from the sequencer
// Notes: event inputs are levels sampled on sys_clk; rises count as events
// Notes on behaviour
// - rtc alarm wakes if enabled, not after reset
// - power button always wakes, every context
// - gpio wakes only from ordinary sleep
// - in_n_a native unless pin in gpio mode
// - audio sets bus-zero status, wakes if enabled
// - primary pm event: sleep, power loss, enabled
// - pcie wake unless disabled, not after reset
// - smbus alert only in native pin mode
// - slave message 01h always wakes, not deep
// - management wake always, except deep sleep
// - lan override enables in_n_a everywhere
// - ac change leaves deep sleep to sleep only
// - usb connect enable only in deep contexts
// - usb port needs its deep enable bit set
// - usb route mode must select wake
// - battery low blocks every wake and exit
// - 72 gpio status bits, tier two summarised
// - reset types are the seven forced-off causes
// - blocked wakes latched, acted on after release
// - wake status set on every wake request, not on a deep exit
`timescale 1ns/1ns
`default_nettype none
`include "swq_regs.svh"
module swq_wake_qualifier
  import swq_pkg::*;
#(
  parameter int NUM_GPIO = 72,
  parameter int NUM_USB = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`SWQ_ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [`SWQ_ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire swq_pstate_t sleepState,
  input wire logic afterPowerLoss,
  input wire logic [`SWQ_RST_TYPES-1:0] resetCause,
  input wire logic g3Event,
  input wire logic batteryLowN,
  input wire logic rtcAlarm,
  input wire logic powerButtonPress,
  input wire logic inNA,
  input wire logic pcieWakeN,
  input wire logic smbusAlertInN,
  input wire logic meWakeReq,
  input wire logic primaryPmEvt,
  input wire logic secondaryPmEvt,
  input wire logic audioWakeEvt,
  input wire logic hostNotifyMsg,
  input wire logic slaveMsgValid,
  input wire logic [7:0] slaveMsgCmd,
  input wire logic [NUM_GPIO-1:0] gpioTier1Evt,
  input wire logic gpioTier2Evt,
  input wire logic [NUM_USB-1:0] usbConnect,
  input wire logic acPowerPresent,
  output logic wakeReq,
  output logic deepExitReq,
  output logic wakeStatus
);
  localparam int GP_WORDS = (NUM_GPIO + 31) / 32;
  localparam int GP_PAD = GP_WORDS * 32;
  localparam int NUM_LVL = 12;
  localparam int EV_W = NUM_LVL + NUM_GPIO + NUM_USB;

  typedef struct packed {
    logic [`SWQ_CTRL_W-1:0] ctrl;
    logic [`SWQ_STAT_W-1:0] stat;
    logic [NUM_USB-1:0] usbEn;
    logic [NUM_GPIO-1:0] gpEn;
    logic [NUM_GPIO-1:0] gpSt;
    logic pend;
    logic pendAc;
    logic wakeReq;
    logic deepExit;
    swq_pstate_t prevState;
  } swq_main_t;

  swq_main_t st_ff;
  swq_main_t nxt_st;

  logic wrEn;
  logic [`SWQ_ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrErr;
  logic [`SWQ_ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic rdErr;
  logic [EV_W-1:0] evLvl;
  logic [EV_W-1:0] evRise;
  logic [EV_W-1:0] evFall;
  logic [3:0] ctx;
  logic afterReset;
  logic [NUM_GPIO-1:0] gpRise;
  logic [NUM_USB-1:0] usbRise;

  function automatic logic [31:0] strbMask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] strb);
    return (old & ~strbMask(strb)) | (d & strbMask(strb));
  endfunction

  // one-hot context column for the present sleep situation
  function automatic logic [3:0] ctxOf(input swq_pstate_t s, input logic loss, input logic rstType);
    logic [3:0] c;
    c = `SWQ_CTX_NONE;
    case (s)
      SWQ_SX, SWQ_SX_AFTER_DEEP: begin
        if (rstType) begin
          c = `SWQ_CTX_RESET;
        end else if (loss) begin
          c = `SWQ_CTX_LOSS;
        end else begin
          c = `SWQ_CTX_SX;
        end
      end
      SWQ_DEEP: begin
        c = `SWQ_CTX_DEEP;
      end
      default: begin
        c = `SWQ_CTX_NONE;
      end
    endcase
    return c;
  endfunction

  function automatic logic permit(input logic [3:0] mask, input logic [3:0] c);
    return |(mask & c);
  endfunction

  function automatic logic isGpWord(input logic [`SWQ_ADDR_W-1:0] a, input logic [`SWQ_ADDR_W-1:0] base);
    logic hit;
    hit = 1'b0;
    for (int w = 0; w < GP_WORDS; w++) begin
      if (a == base + `SWQ_ADDR_W'(w * 4)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  swq_axil_slave u_bus (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrErr),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  assign evLvl = {usbConnect, gpioTier1Evt, acPowerPresent, gpioTier2Evt, hostNotifyMsg, audioWakeEvt,
                  secondaryPmEvt, primaryPmEvt, meWakeReq, ~smbusAlertInN, ~pcieWakeN, ~inNA,
                  powerButtonPress, rtcAlarm};

  swq_edge_det #(.W(EV_W)) u_edge (
    .sys_clk(sys_clk),
    .rst(rst),
    .clkEn(clkEn),
    .sig(evLvl),
    .rise(evRise),
    .fall(evFall)
  );

  assign gpRise = evRise[NUM_LVL +: NUM_GPIO];
  assign usbRise = evRise[NUM_LVL + NUM_GPIO +: NUM_USB];
  assign afterReset = |resetCause;
  assign ctx = ctxOf(sleepState, afterPowerLoss, afterReset);

  assign wrErr = ~((wrAddr == `SWQ_OFS_CTRL) | (wrAddr == `SWQ_OFS_STAT) | (wrAddr == `SWQ_OFS_USBEN) |
                   isGpWord(wrAddr, `SWQ_OFS_GPEN0) | isGpWord(wrAddr, `SWQ_OFS_GPST0));

  always_comb begin
    logic [GP_PAD-1:0] enPad;
    logic [GP_PAD-1:0] stPad;
    rdData = 32'h00000000;
    rdErr = 1'b0;
    enPad = GP_PAD'(st_ff.gpEn);
    stPad = GP_PAD'(st_ff.gpSt);
    if (rdAddr == `SWQ_OFS_CTRL) begin
      rdData = 32'(st_ff.ctrl);
    end else if (rdAddr == `SWQ_OFS_STAT) begin
      rdData = 32'({~batteryLowN, st_ff.pend, st_ff.stat});
    end else if (rdAddr == `SWQ_OFS_USBEN) begin
      rdData = 32'(st_ff.usbEn);
    end else if (isGpWord(rdAddr, `SWQ_OFS_GPEN0)) begin
      for (int w = 0; w < GP_WORDS; w++) begin
        if (rdAddr == `SWQ_OFS_GPEN0 + `SWQ_ADDR_W'(w * 4)) begin
          rdData = enPad[w*32 +: 32];
        end
      end
    end else if (isGpWord(rdAddr, `SWQ_OFS_GPST0)) begin
      for (int w = 0; w < GP_WORDS; w++) begin
        if (rdAddr == `SWQ_OFS_GPST0 + `SWQ_ADDR_W'(w * 4)) begin
          rdData = stPad[w*32 +: 32];
        end
      end
    end else begin
      rdErr = 1'b1;
    end
  end

  always_comb begin
    logic [GP_PAD-1:0] enPad;
    logic [GP_PAD-1:0] stPad;
    logic lanEn;
    logic b0Evt;
    logic usbDeepHit;
    logic slvHit;
    logic hit;
    logic acHit;
    logic blocked;
    logic asleep;
    nxt_st = st_ff;
    enPad = GP_PAD'(st_ff.gpEn);
    stPad = GP_PAD'(st_ff.gpSt);
    // software writes first, so hardware sets below win over clears
    if (wrEn) begin
      if (wrAddr == `SWQ_OFS_CTRL) begin
        nxt_st.ctrl = `SWQ_CTRL_W'(merge(32'(st_ff.ctrl), wrData, wrStrb));
      end
      if (wrAddr == `SWQ_OFS_STAT) begin
        nxt_st.stat = st_ff.stat & ~`SWQ_STAT_W'(wrData & strbMask(wrStrb));
      end
      if (wrAddr == `SWQ_OFS_USBEN) begin
        nxt_st.usbEn = NUM_USB'(merge(32'(st_ff.usbEn), wrData, wrStrb));
      end
      for (int w = 0; w < GP_WORDS; w++) begin
        if (wrAddr == `SWQ_OFS_GPEN0 + `SWQ_ADDR_W'(w * 4)) begin
          enPad[w*32 +: 32] = merge(enPad[w*32 +: 32], wrData, wrStrb);
        end
        if (wrAddr == `SWQ_OFS_GPST0 + `SWQ_ADDR_W'(w * 4)) begin
          stPad[w*32 +: 32] = stPad[w*32 +: 32] & ~(wrData & strbMask(wrStrb));
        end
      end
    end
    nxt_st.gpEn = enPad[NUM_GPIO-1:0];
    nxt_st.gpSt = stPad[NUM_GPIO-1:0] | gpRise;
    // native alert mode is lost on power loss or on entering deep sleep
    nxt_st.prevState = sleepState;
    if (g3Event || (sleepState == SWQ_DEEP && st_ff.prevState != SWQ_DEEP)) begin
      nxt_st.ctrl[`SWQ_C_ALERTNAT] = 1'b0;
    end
    lanEn = ~st_ff.ctrl[`SWQ_C_LANGPIO] | st_ff.ctrl[`SWQ_C_LANOVR];
    // ordinary-sleep usb connects ride the bus-zero path
    b0Evt = evRise[6] | (|usbRise & sleepState == SWQ_SX);
    usbDeepHit = st_ff.ctrl[`SWQ_C_USBDEEP] & st_ff.ctrl[`SWQ_C_USBMODE]
                 & |(usbRise & st_ff.usbEn)
                 & (sleepState == SWQ_DEEP || sleepState == SWQ_SX_AFTER_DEEP);
    slvHit = slaveMsgValid & (slaveMsgCmd == `SWQ_SLV_WAKE_CMD);
    // status bits record events whatever the context
    if (evRise[0]) nxt_st.stat[`SWQ_S_RTC] = 1'b1;
    if (evRise[1]) nxt_st.stat[`SWQ_S_PWRBTN] = 1'b1;
    if (evRise[2]) nxt_st.stat[`SWQ_S_LAN] = 1'b1;
    if (evRise[3]) nxt_st.stat[`SWQ_S_PCIE] = 1'b1;
    if (evRise[4]) nxt_st.stat[`SWQ_S_ALERT] = 1'b1;
    if (evRise[5]) nxt_st.stat[`SWQ_S_ME] = 1'b1;
    if (b0Evt || evRise[8]) nxt_st.stat[`SWQ_S_B0] = 1'b1;
    if (evRise[7]) nxt_st.stat[`SWQ_S_SEC] = 1'b1;
    if (evRise[9]) nxt_st.stat[`SWQ_S_SMBWK] = 1'b1;
    if (evRise[10]) nxt_st.stat[`SWQ_S_TIER2] = 1'b1;
    if (evRise[11] || evFall[11]) nxt_st.stat[`SWQ_S_AC] = 1'b1;
    if (|usbRise) nxt_st.stat[`SWQ_S_USB] = 1'b1;
    if (slvHit) nxt_st.stat[`SWQ_S_SLV] = 1'b1;
    // sources gated by their context column and any enable; usb deep wake by sleep state instead
    hit = (evRise[0] & st_ff.ctrl[`SWQ_C_RTC] & permit(`SWQ_PERM_RTC, ctx))
        | (evRise[1] & permit(`SWQ_PERM_PWRBTN, ctx))
        | (evRise[2] & lanEn & permit(`SWQ_PERM_LAN, ctx))
        | (evRise[3] & ~st_ff.ctrl[`SWQ_C_PCIEDIS] & permit(`SWQ_PERM_PCIE, ctx))
        | (evRise[4] & st_ff.ctrl[`SWQ_C_ALERTNAT] & permit(`SWQ_PERM_ALERT, ctx))
        | (evRise[5] & permit(`SWQ_PERM_ME, ctx))
        | (b0Evt & st_ff.ctrl[`SWQ_C_B0] & permit(`SWQ_PERM_PRI, ctx))
        | (evRise[7] & st_ff.ctrl[`SWQ_C_SEC] & permit(`SWQ_PERM_SEC, ctx))
        | (evRise[8] & st_ff.ctrl[`SWQ_C_AUDIO] & permit(`SWQ_PERM_AUDIO, ctx))
        | (evRise[9] & st_ff.ctrl[`SWQ_C_HNWK] & permit(`SWQ_PERM_HN, ctx))
        | (evRise[10] & st_ff.ctrl[`SWQ_C_TIER2] & permit(`SWQ_PERM_GPIO, ctx))
        | (|(gpRise & st_ff.gpEn) & permit(`SWQ_PERM_GPIO, ctx))
        | (slvHit & permit(`SWQ_PERM_SLV, ctx))
        | usbDeepHit;
    acHit = (evRise[11] | evFall[11]) & st_ff.ctrl[`SWQ_C_ACWK] & (sleepState == SWQ_DEEP);
    asleep = sleepState != SWQ_S0;
    blocked = ~batteryLowN;
    nxt_st.wakeReq = 1'b0;
    nxt_st.deepExit = 1'b0;
    if (!asleep) begin
      nxt_st.pend = 1'b0;
      nxt_st.pendAc = 1'b0;
    end else if (blocked) begin
      // hold events until battery low releases
      nxt_st.pend = st_ff.pend | hit;
      nxt_st.pendAc = st_ff.pendAc | acHit;
    end else begin
      nxt_st.wakeReq = hit | st_ff.pend;
      nxt_st.deepExit = (acHit | st_ff.pendAc) & ~(hit | st_ff.pend);
      nxt_st.pend = 1'b0;
      nxt_st.pendAc = 1'b0;
    end
    if (nxt_st.wakeReq) begin
      nxt_st.stat[`SWQ_S_WAKE] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.ctrl <= `SWQ_CTRL_RST;
      st_ff.stat <= `SWQ_STAT_RST;
      st_ff.prevState <= SWQ_S0;
    end else if (clkEn) begin
      st_ff <= nxt_st;
    end
  end

  assign wakeReq = st_ff.wakeReq;
  assign deepExitReq = st_ff.deepExit;
  assign wakeStatus = st_ff.stat[`SWQ_S_WAKE];
endmodule
`default_nettype wire

// [tb/sleep_wake_event_qualifier_bench.sv]
// Purpose: self-checking bench of the wake qualifier
// Assumes: agent drives every wake event pin; g3Event and batteryLowN come from the bench
// Notes: registers reached through AXI4-Lite tasks
`timescale 1ns/1ns
`default_nettype none
`include "swq_regs.svh"
module sleep_wake_event_qualifier_bench
  import swq_pkg::*;
;
  logic sys_clk, rst, clkEn, awvalid, wvalid, bready, arvalid, rready, g3Event, batteryLowN, afterPowerLoss, fire;
  logic awready, wready, bvalid, arready, rvalid, wakeReq, deepExitReq, wakeStatus, acLvl, slvValid;
  logic [7:0] awaddr, araddr, slvCmd;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb, sel;
  logic [1:0] bresp, rresp, rs;
  logic [15:0] act;
  logic [71:0] gpio;
  logic [6:0] resetCause, gpioIdx;
  swq_pstate_t sleepState;
  int err_total, check_count;
  wire logic rtcAlarm = act[0], powerButtonPress = act[1], meWakeReq = act[2], primaryPmEvt = act[3];
  wire logic secondaryPmEvt = act[4], audioWakeEvt = act[5], hostNotifyMsg = act[6], gpioTier2Evt = act[7];
  wire logic inNA = ~act[8], pcieWakeN = ~act[9], smbusAlertInN = ~act[10], acPowerPresent = acLvl;
  wire logic slaveMsgValid = slvValid;
  wire logic [7:0] slaveMsgCmd = slvCmd;
  wire logic [71:0] gpioTier1Evt = gpio;
  wire logic [15:0] usbConnect = {16{act[13]}};
  swq_wake_qualifier DUT (.*);
  swq_wake_agent agent (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic results();
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 50) begin
      err_total++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic gotA, gotW;
    gotA = 1'b0;
    gotW = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && !(gotA && gotW); n++) begin
      @(posedge sys_clk);
      if (awvalid && awready) begin
        gotA = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        gotW = 1'b1;
        wvalid <= 1'b0;
      end
    end
    guard(n);
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (bvalid) break;
    end
    rs = bresp;
    guard(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (arready) break;
    end
    arvalid <= 1'b0;
    guard(n);
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (rvalid) break;
    end
    rv = rdata;
    rs = rresp;
    guard(n);
  endtask
  // fire one event, expect {wake, deep exit} within six cycles
  task automatic ev(input logic [3:0] s, input logic [1:0] e);
    logic [1:0] got;
    got = 2'h0;
    sel <= s;
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (6) begin
      @(posedge sys_clk);
      got = got | {wakeReq, deepExitReq};
    end
    chk("wake and deep exit", {30'h0, got}, {30'h0, e});
  endtask
  task automatic t_regs();
    rd(`SWQ_OFS_CTRL);
    chk("ctrl", rv, 32'h0);
    chk("rresp", {30'h0, rs}, {30'h0, `SWQ_RESP_OKAY});
    rd(8'hF0);
    chk("rresp", {30'h0, rs}, {30'h0, `SWQ_RESP_SLVERR});
    wr(8'hF0, 32'hFFFF);
    chk("bresp", {30'h0, rs}, {30'h0, `SWQ_RESP_SLVERR});
  endtask
  task automatic t_rst();
    ev(4'h0, 2'h0);
    wr(`SWQ_OFS_CTRL, 32'h1);
    ev(4'h0, 2'h2);
    chk("wake status", {31'h0, wakeStatus}, 32'h1);
    rd(`SWQ_OFS_STAT);
    chk("status", rv & 32'h11, 32'h11);
    wr(`SWQ_OFS_STAT, 32'h3FFF);
    chk("wake status", {31'h0, wakeStatus}, 32'h0);
    rd(`SWQ_OFS_STAT);
    chk("status", rv & 32'h3FFF, 32'h0);
    for (int i = 0; i < 7; i++) begin
      resetCause <= 7'h1 << i;
      ev(4'h0, 2'h0);
      ev(4'h1, 2'h2);
      ev(4'h2, 2'h2);
    end
    resetCause <= 7'h0;
  endtask
  task automatic t_deep();
    sleepState <= SWQ_DEEP;
    wr(`SWQ_OFS_GPEN0, 32'h1);
    wr(`SWQ_OFS_USBEN, 32'hFFFF);
    wr(`SWQ_OFS_CTRL, 32'h38F);
    ev(4'h1, 2'h2);
    ev(4'h0, 2'h2);
    ev(4'h2, 2'h0);
    ev(4'hE, 2'h0);
    ev(4'h3, 2'h0);
    ev(4'h4, 2'h0);
    ev(4'hC, 2'h0);
    ev(4'h9, 2'h2);
    ev(4'h8, 2'h2);
    ev(4'hD, 2'h2);
    ev(4'hB, 2'h1);
    wr(`SWQ_OFS_CTRL, 32'h99F);
    ev(4'h9, 2'h0);
    ev(4'h8, 2'h0);
    ev(4'hD, 2'h0);
    wr(`SWQ_OFS_CTRL, 32'hBDF);
    wr(`SWQ_OFS_USBEN, 32'h0);
    ev(4'h8, 2'h2);
    ev(4'hD, 2'h0);
    wr(`SWQ_OFS_CTRL, 32'h0);
    ev(4'hB, 2'h0);
  endtask
  task automatic t_sx();
    sleepState <= SWQ_SX;
    wr(`SWQ_OFS_STAT, 32'h3FFF);
    wr(`SWQ_OFS_CTRL, 32'h142F);
    wr(`SWQ_OFS_GPEN0 + 8'h08, 32'h80);
    gpioIdx <= 7'h47;
    ev(4'hC, 2'h2);
    rd(`SWQ_OFS_GPST0 + 8'h08);
    chk("gpio status", rv, 32'h80);
    ev(4'h7, 2'h2);
    ev(4'h6, 2'h2);
    ev(4'h5, 2'h2);
    ev(4'hD, 2'h2);
    rd(`SWQ_OFS_STAT);
    chk("status", rv & 32'hE, 32'hE);
    ev(4'hF, 2'h0);
    ev(4'hE, 2'h2);
    ev(4'hA, 2'h2);
    g3Event <= 1'b1;
    @(posedge sys_clk);
    g3Event <= 1'b0;
    ev(4'hA, 2'h0);
    afterPowerLoss <= 1'b1;
    ev(4'h3, 2'h2);
    ev(4'h4, 2'h2);
    ev(4'hC, 2'h0);
    ev(4'h5, 2'h0);
    afterPowerLoss <= 1'b0;
    gpioIdx <= 7'h46;
    ev(4'hC, 2'h0);
    sleepState <= SWQ_S0;
    ev(4'h1, 2'h0);
  endtask
  task automatic t_battery_low_n();
    logic got;
    got = 1'b0;
    sleepState <= SWQ_SX;
    batteryLowN <= 1'b0;
    ev(4'h1, 2'h0);
    batteryLowN <= 1'b1;
    repeat (4) begin
      @(posedge sys_clk);
      got = got | wakeReq;
    end
    chk("latched wake", {31'h0, got}, 32'h1);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, fire, g3Event, afterPowerLoss} = 8'h0;
    {rst, clkEn, batteryLowN} = 3'h7;
    {awaddr, araddr, wdata, sel, gpioIdx, resetCause} = 66'h0;
    wstrb = 4'hF;
    sleepState = SWQ_SX;
    err_total = 0;
    check_count = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_rst();
    t_deep();
    t_sx();
    t_battery_low_n();
    results();
  end
endmodule
`default_nettype wire

// [tb/swq_wake_agent.sv]
// Purpose: platform model of wake pins, agents and slave messages
// Assumes: one event asked for at a time
// Notes: act and gpio events held two cycles then idle; slave valid one cycle; ac level toggles and stays
`timescale 1ns/1ns
`default_nettype none
module swq_wake_agent (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [3:0] sel,
  input wire logic [6:0] gpioIdx,
  output logic [15:0] act,
  output logic acLvl,
  output logic [71:0] gpio,
  output logic slvValid,
  output logic [7:0] slvCmd
);
  logic hold;
  assign gpio = act[12] ? (72'h1 << gpioIdx) : 72'h0;
  always_ff @(posedge sys_clk) begin
    slvValid <= fire && sel[3:1] == 3'h7;
    // command lines wander when no message is offered
    slvCmd <= rst ? 8'h0 : (fire ? (sel[0] ? 8'h02 : 8'h01) : ~slvCmd);
    if (rst) begin
      act <= 16'h0;
      hold <= 1'b0;
      acLvl <= 1'b0;
    end else if (fire) begin
      act <= 16'h1 << sel;
      hold <= 1'b1;
      acLvl <= acLvl ^ (sel == 4'hB);
    end else if (hold) begin
      hold <= 1'b0;
    end else begin
      act <= 16'h0;
    end
  end
endmodule
`default_nettype wire

// [tb/swq_wake_qualifier_checker.sv]
// Purpose: port-level properties of the wake qualifier
// Assumes: one clock domain, synchronous reset
// Notes: bound to the top module below
`timescale 1ns/1ns
`default_nettype none
module swq_wake_qualifier_checker
  import swq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire swq_pstate_t sleepState,
  input wire logic batteryLowN,
  input wire logic powerButtonPress,
  input wire logic meWakeReq,
  input wire logic slaveMsgValid,
  input wire logic [7:0] slaveMsgCmd,
  input wire logic bvalid,
  input wire logic wakeReq,
  input wire logic deepExitReq,
  input wire logic wakeStatus
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_open;
    clkEn && batteryLowN && sleepState != SWQ_S0;
  endsequence
  property p_s0_quiet;
    $past(sleepState) == SWQ_S0 |-> !wakeReq && !deepExitReq;
  endproperty
  a_s0_quiet: assert property (p_s0_quiet) else $error("wake while awake");
  property p_battery_low_n;
    !$past(batteryLowN) |-> !wakeReq && !deepExitReq;
  endproperty
  a_battery_low_n: assert property (p_battery_low_n) else $error("wake under battery low");
  property p_status;
    wakeReq |-> wakeStatus;
  endproperty
  a_status: assert property (p_status) else $error("wake without status");
  property p_deep_exit;
    deepExitReq |-> !wakeReq && $past(sleepState) == SWQ_DEEP;
  endproperty
  a_deep_exit: assert property (p_deep_exit) else $error("bad deep exit");
  property p_pwrbtn;
    $rose(powerButtonPress) ##0 s_open |=> wakeReq;
  endproperty
  a_pwrbtn: assert property (p_pwrbtn) else $error("button did not wake");
  property p_mgmt;
    $rose(meWakeReq) ##0 s_open ##0 sleepState != SWQ_DEEP |=> wakeReq;
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("mgmt did not wake");
  property p_slave;
    slaveMsgValid && slaveMsgCmd == 8'h01 ##0 s_open ##0 sleepState != SWQ_DEEP |-> ##[1:2] wakeReq;
  endproperty
  a_slave: assert property (p_slave) else $error("slave message did not wake");
  property p_clear;
    $fell(wakeStatus) && !$past(rst) |-> bvalid;
  endproperty
  a_clear: assert property (p_clear) else $error("status fell without write");
  c_wake: cover property (wakeReq);
  c_exit: cover property (deepExitReq);
  c_clear: cover property ($fell(wakeStatus));
endmodule
bind swq_wake_qualifier swq_wake_qualifier_checker u_chk (.*);
`default_nettype wire
